// >>> rtl/spics_top.sv
// spi control/status register, serial engine and pin control
`timescale 1ns/1ps
`default_nettype none
`include "spics_params.svh"
module spics_top (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // special function register port
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_bit_wr,
  input  wire logic [2:0]           sfr_bit_sel,
  input  wire logic                 sfr_bit_val,
  input  wire spics_pkg::spics_byte_t sfr_wdata,
  input  wire logic                 sfr_rd,
  output spics_pkg::spics_byte_t    sfr_rdata,
  // interrupt
  input  wire logic                 spi_irq_en,
  output logic                      spi_irq,
  // serial clock pin
  input  wire logic                 sck_in,
  output logic                      sck_out,
  output logic                      sck_oe,
  // master out pin
  input  wire logic                 mosi_in,
  output logic                      mosi_out,
  output logic                      mosi_oe,
  // master in pin
  input  wire logic                 miso_in,
  output logic                      miso_out,
  output logic                      miso_oe,
  // slave select pin
  input  wire logic                 slave_select_line_in,
  output logic                      slave_select_line_out,
  output logic                      slave_select_line_oe
);
  import spics_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic            sck_d_r;
  logic            sck_s;
  logic            mosi_s;
  logic            miso_s;
  logic            nss_s;
  logic            sck_rise;
  logic            sck_fall;

  assign pin_raw = {slave_select_line_in, miso_in, mosi_in, sck_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      // select resets high so a floating start does not look selected
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          pin_s1_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
          pin_s2_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  assign sck_s  = pin_s2_r[0];
  assign mosi_s = pin_s2_r[1];
  assign miso_s = pin_s2_r[2];
  assign nss_s  = pin_s2_r[3];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  ////////////////////////////////////////////////////////////////////////
  // register access decode

  logic           port_enable_r;
  logic [1:0]     select_pin_mode_r;
  logic           master_select_r;
  logic [3:0]     flags_r;
  logic [3:0]     flag_set;
  logic           tx_buffer_empty_r;
  spics_byte_t    tx_buf_r;
  spics_byte_t    wr_mask;
  spics_byte_t    wr_val;
  spics_byte_t    ctl_mask;
  logic           dat_wr;
  logic           dat_rd;
  logic           tx_load;
  logic           tx_take;
  logic           write_collision_flag_set;

  // bit access writes one lane; byte access writes all eight
  assign wr_mask  = sfr_wr ? 8'hFF : (sfr_bit_wr ? (8'h01 << sfr_bit_sel) : 8'h00);
  assign wr_val   = sfr_wr ? sfr_wdata : {8{sfr_bit_val}};
  assign ctl_mask = (sfr_addr == `SPICS_CTL_ADDR) ? wr_mask : 8'h00; // see (R14)
  assign dat_wr   = sfr_wr & (sfr_addr == `SPICS_DAT_ADDR);
  assign dat_rd   = sfr_rd & (sfr_addr == `SPICS_DAT_ADDR);
  assign write_collision_flag_set = dat_wr & ~tx_buffer_empty_r; // see (R4)
  assign tx_load  = dat_wr & tx_buffer_empty_r; // see (R15)

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_enable_r     <= `SPICS_EN_RST;
      select_pin_mode_r <= `SPICS_MODE_RST;
    end else begin
      if (ctl_mask[`SPICS_BIT_EN]) begin
        port_enable_r <= wr_val[`SPICS_BIT_EN]; // see (R13)
      end
      if (ctl_mask[`SPICS_BIT_MODE_LO]) begin
        select_pin_mode_r[0] <= wr_val[`SPICS_BIT_MODE_LO];
      end
      if (ctl_mask[`SPICS_BIT_MODE_HI]) begin
        select_pin_mode_r[1] <= wr_val[`SPICS_BIT_MODE_HI];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      master_select_r <= `SPICS_MSTSEL_RST;
    end else if (sfr_wr && sfr_addr == `SPICS_CFG_ADDR) begin
      master_select_r <= sfr_wdata[`SPICS_BIT_MSTSEL]; // see (R16)
    end
  end

  // only a software write clears a flag; a same-cycle set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flag_set | (flags_r & ~ctl_mask[7:4]) | (wr_val[7:4] & ctl_mask[7:4]); // see (R2) (R17)
    end
  end

  // collision leaves the buffer and its empty bit untouched
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buffer_empty_r <= 1'b1;
      tx_buf_r          <= 8'h00;
    end else if (tx_load) begin
      tx_buffer_empty_r <= 1'b0; // see (R11) (R5)
      tx_buf_r          <= sfr_wdata;
    end else if (tx_take) begin
      tx_buffer_empty_r <= 1'b1; // see (R12)
    end
  end

  assign spi_irq = spi_irq_en & (|flags_r); // see (R3)

  ////////////////////////////////////////////////////////////////////////
  // select pin modes

  logic mst_active;
  logic slv_active;
  logic slv_sel;
  logic mode_fault_flag_cond;

  assign mst_active = port_enable_r & master_select_r;
  assign slv_active = port_enable_r & ~master_select_r;
  assign mode_fault_flag_cond  = mst_active & (select_pin_mode_r == SPICS_SEL_INPUT) & ~nss_s; // see (R6)
  // three wire ignores the pin entirely
  assign slv_sel    = slv_active & ~((select_pin_mode_r == SPICS_SEL_INPUT) & nss_s); // see (R8) (R9)

  assign slave_select_line_out = select_pin_mode_r[0]; // see (R10)
  assign slave_select_line_oe  = port_enable_r & select_pin_mode_r[1]; // see (R10) (R9)

  ////////////////////////////////////////////////////////////////////////
  // serial engine

  spics_mstate_t mstate_r;
  logic [3:0]    div_r;
  logic [2:0]    bit_cnt_r;
  spics_byte_t   shreg_r;
  logic          samp_r;
  logic          slv_loaded_r;
  logic          div_end;
  logic          mst_start;
  logic          slv_load;
  logic          mst_last;
  logic          slv_last;
  logic          rx_in_valid;
  logic          rx_in_ready;
  spics_byte_t   rx_in_data;
  logic          rx_out_valid;
  spics_byte_t   rx_out_data;

  assign div_end   = (div_r == `SPICS_SCK_HALF_CYC - 4'h1);
  // master waits for room in the receive buffer, so it never drops a byte
  assign mst_start = (mstate_r == SPICS_M_IDLE) & mst_active & ~tx_buffer_empty_r & rx_in_ready & ~mode_fault_flag_cond;
  assign slv_load  = slv_sel & (bit_cnt_r == 3'h0) & ~slv_loaded_r & ~tx_buffer_empty_r & ~sck_rise;
  assign tx_take   = mst_start | slv_load; // see (R12)
  assign mst_last  = (mstate_r == SPICS_M_HIGH) & div_end & (bit_cnt_r == 3'h7);
  assign slv_last  = slv_sel & sck_rise & (bit_cnt_r == 3'h7);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mstate_r <= SPICS_M_IDLE;
      div_r    <= 4'h0;
    end else if (!mst_active || mode_fault_flag_cond) begin
      mstate_r <= SPICS_M_IDLE;
      div_r    <= 4'h0;
    end else begin
      unique case (mstate_r)
        SPICS_M_IDLE: begin
          div_r <= 4'h0;
          if (mst_start) begin
            mstate_r <= SPICS_M_LOW;
          end
        end
        SPICS_M_LOW: begin
          div_r <= div_end ? 4'h0 : div_r + 4'h1;
          if (div_end) begin
            mstate_r <= SPICS_M_HIGH;
          end
        end
        SPICS_M_HIGH: begin
          div_r <= div_end ? 4'h0 : div_r + 4'h1;
          if (div_end) begin
            mstate_r <= mst_last ? SPICS_M_IDLE : SPICS_M_LOW;
          end
        end
        default: begin
          mstate_r <= SPICS_M_IDLE;
          div_r    <= 4'h0;
        end
      endcase
    end
  end

  // shifter, sample bit and bit count serve both master and slave
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shreg_r      <= 8'h00;
      samp_r       <= 1'b0;
      bit_cnt_r    <= 3'h0;
      slv_loaded_r <= 1'b0;
    end else if (mst_active) begin
      slv_loaded_r <= 1'b0;
      if (mode_fault_flag_cond || mstate_r == SPICS_M_IDLE) begin
        bit_cnt_r <= 3'h0;
        if (mst_start) begin
          shreg_r <= tx_buf_r;
        end
      end else if (mstate_r == SPICS_M_LOW && div_end) begin
        samp_r <= miso_s;
      end else if (mstate_r == SPICS_M_HIGH && div_end) begin
        shreg_r   <= {shreg_r[6:0], samp_r};
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end else if (!slv_sel) begin
      bit_cnt_r    <= 3'h0;
      slv_loaded_r <= 1'b0;
    end else begin
      if (slv_load) begin
        shreg_r      <= tx_buf_r;
        slv_loaded_r <= 1'b1;
      end
      if (sck_rise) begin
        samp_r    <= mosi_s;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (slv_last) begin
          slv_loaded_r <= 1'b0;
        end
      end else if (sck_fall && bit_cnt_r != 3'h0) begin
        shreg_r <= {shreg_r[6:0], samp_r};
      end
    end
  end

  assign rx_in_valid = mst_last | slv_last;
  assign rx_in_data  = mst_last ? {shreg_r[6:0], samp_r} : {shreg_r[6:0], mosi_s};

  always_comb begin
    flag_set                        = 4'h0;
    flag_set[`SPICS_BIT_DONE - 4]   = rx_in_valid; // see (R1)
    flag_set[`SPICS_BIT_WRITE_COLLISION_FLAG - 4]   = write_collision_flag_set; // see (R4)
    flag_set[`SPICS_BIT_MODE_FAULT_FLAG - 4]   = mode_fault_flag_cond; // see (R6)
    flag_set[`SPICS_BIT_OVR - 4]    = slv_last & rx_out_valid; // see (R7)
  end

  spics_buf2 #(
    .WIDTH (8)
  ) u_rx_buf (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_in_data),
    .out_valid (rx_out_valid),
    .out_ready (dat_rd),
    .out_data  (rx_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // pins and read data

  assign sck_out  = (mstate_r == SPICS_M_HIGH);
  assign sck_oe   = mst_active;
  assign mosi_out = shreg_r[7];
  assign mosi_oe  = mst_active;
  assign miso_out = shreg_r[7];
  assign miso_oe  = slv_sel;

  logic busy;
  assign busy = (mstate_r != SPICS_M_IDLE) | (slv_active & (bit_cnt_r != 3'h0));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `SPICS_CTL_ADDR: begin
          sfr_rdata <= {flags_r, select_pin_mode_r, tx_buffer_empty_r, port_enable_r};
        end
        `SPICS_CFG_ADDR: begin
          sfr_rdata <= {busy, master_select_r, 2'b00, slv_sel, nss_s,
                        ~(slv_active & slv_loaded_r) | mst_active, ~rx_out_valid};
        end
        `SPICS_DAT_ADDR: begin
          sfr_rdata <= rx_out_valid ? rx_out_data : 8'h00; // see (R15)
        end
        default: begin
          sfr_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule // spics_top
`default_nettype wire

// >>> shared/spics_params.svh
// constants of the spi control and status logic
// Summary of operation
// (R1) transfer end sets done flag, bit 7
// (R2) flags stay set until software clears
// (R3) any flag with enable raises interrupt
// (R4) data write while tx full sets collision
// (R5) colliding write is dropped, buffer kept
// (R6) master, mode 01, select low: mode fault
// (R7) slave byte into unread buffer: overrun
// (R8) mode 00: three wire, select unused
// (R9) mode 01 default: select is input
// (R10) mode 1x: select driven with low bit
// (R11) data write clears tx empty, bit 1
// (R12) move to shifter sets tx empty
// (R13) bit 0 enables port, reset zero
// (R14) control at 0xF8, bit and byte access
// (R15) data write loads tx, read gives rx
// (R16) master select: 1 master, 0 slave
// (R17) zero write clears, hardware set wins
`ifndef SPICS_PARAMS_SVH
`define SPICS_PARAMS_SVH

`define SPICS_CTL_ADDR      8'hF8
`define SPICS_CFG_ADDR      8'hA1
`define SPICS_DAT_ADDR      8'hA3

`define SPICS_BIT_DONE      7
`define SPICS_BIT_WRITE_COLLISION_FLAG      6
`define SPICS_BIT_MODE_FAULT_FLAG      5
`define SPICS_BIT_OVR       4
`define SPICS_BIT_MODE_HI   3
`define SPICS_BIT_MODE_LO   2
`define SPICS_BIT_TXE       1
`define SPICS_BIT_EN        0
`define SPICS_BIT_MSTSEL    6

`define SPICS_MODE_RST      2'h1
`define SPICS_MSTSEL_RST    1'b0
`define SPICS_EN_RST        1'b0

`define SPICS_SCK_HALF_CYC  4'h4

`endif

// >>> shared/spics_pkg.sv
// types of the spi control and status logic
package spics_pkg;

  typedef enum logic [2:0] {
    SPICS_M_IDLE = 3'b001,
    SPICS_M_LOW  = 3'b010,
    SPICS_M_HIGH = 3'b100
  } spics_mstate_t;

  typedef enum logic [1:0] {
    SPICS_SEL_3WIRE = 2'b00,
    SPICS_SEL_INPUT = 2'b01,
    SPICS_SEL_OUT_0 = 2'b10,
    SPICS_SEL_OUT_1 = 2'b11
  } spics_selmode_t;

  typedef logic [7:0] spics_byte_t;

endpackage

// >>> rtl/spics_buf2.sv
// two-entry receive buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spics_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem0_r;
  logic [WIDTH-1:0] mem1_r;
  logic [1:0]       count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem0_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= 2'h0;
    end else if (push & ~pop) begin
      count_r <= count_r + 2'h1;
    end else if (pop & ~push) begin
      count_r <= count_r - 2'h1;
    end
  end

  // head always sits in mem0 so the read data comes straight from a register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem0_r <= '0;
      mem1_r <= '0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          if (count_r == 2'h0) begin
            mem0_r <= in_data;
          end else begin
            mem1_r <= in_data;
          end
        end
        2'b01: begin
          mem0_r <= mem1_r;
        end
        2'b11: begin
          if (count_r == 2'h1) begin
            mem0_r <= in_data;
          end else begin
            mem0_r <= mem1_r;
            mem1_r <= in_data;
          end
        end
        2'b00: begin
          mem0_r <= mem0_r;
        end
      endcase
    end
  end

endmodule // spics_buf2
`default_nettype wire

// >>> bench/spics_slave_model.sv
// far-side spi slave device model, mode 0
`timescale 1ns/1ps
`default_nettype none
module spics_slave_model (
  // pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // bench side
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  initial begin
    sh      = 8'h00;
    rx_byte = 8'h00;
  end
  // first bit must sit on the line before the first rising edge
  always @(negedge sel_n) sh = tx_byte;
  always @(posedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_n) sh <= {sh[6:0], ~sh[7]};
  // released line must not look like the last bit
  assign miso = sel_n ? ~sh[7] : sh[7];
endmodule // spics_slave_model
`default_nettype wire

// >>> bench/spics_top_assertions.sv
// concurrent checks on the spi control and status ports
`timescale 1ns/1ps
`default_nettype none
`include "spics_params.svh"
module spics_top_assertions (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   arst_n,
  // register port
  input wire logic [7:0]             sfr_addr,
  input wire logic                   sfr_wr,
  input wire logic                   sfr_bit_wr,
  input wire logic [2:0]             sfr_bit_sel,
  input wire logic                   sfr_bit_val,
  input wire spics_pkg::spics_byte_t sfr_wdata,
  input wire logic                   sfr_rd,
  input wire spics_pkg::spics_byte_t sfr_rdata,
  // interrupt and pins
  input wire logic                   spi_irq_en,
  input wire logic                   spi_irq,
  input wire logic                   sck_out,
  input wire logic                   sck_oe,
  input wire logic                   mosi_oe,
  input wire logic                   slave_select_line_out,
  input wire logic                   slave_select_line_oe
);
  import spics_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ctl_sel;
  logic mapped;
  assign ctl_sel = (sfr_addr == `SPICS_CTL_ADDR);
  assign mapped  = ctl_sel || sfr_addr == `SPICS_CFG_ADDR || sfr_addr == `SPICS_DAT_ADDR;
  ////////////////////////////////////////
  property p_irq_mask; !spi_irq_en |-> !spi_irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq without enable");
  property p_irq_flag; sfr_rd && ctl_sel && !sfr_wr && !sfr_bit_wr ##1 spi_irq_en && |sfr_rdata[7:4] |-> spi_irq;
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("flag set but no irq");
  property p_sticky; spi_irq && !sfr_wr && !sfr_bit_wr ##1 spi_irq_en |-> spi_irq; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");
  property p_rd_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; sfr_rd && !mapped |=> sfr_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ss_ctl; sfr_rd && ctl_sel && !sfr_wr && !sfr_bit_wr |=>
    slave_select_line_oe == (sfr_rdata[3] & sfr_rdata[0]) && slave_select_line_out == sfr_rdata[2]; endproperty
  a_ss_ctl: assert property (p_ss_ctl) else $error("select pin not per mode");
  property p_three_wire; sfr_wr && ctl_sel && !sfr_wdata[3] |=> !slave_select_line_oe; endproperty
  a_three_wire: assert property (p_three_wire) else $error("select driven in input mode");
  property p_disable; sfr_bit_wr && !sfr_wr && ctl_sel && sfr_bit_sel == 3'h0 && !sfr_bit_val |=>
    !sck_oe && !slave_select_line_oe; endproperty
  a_disable: assert property (p_disable) else $error("pins driven while disabled");
  property p_sck_high; $rose(sck_out) |-> sck_out [*4] ##1 !sck_out; endproperty
  a_sck_high: assert property (p_sck_high) else $error("sck high half wrong");
  property p_oe_pair; sck_oe == mosi_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("master pins disagree");
endmodule // spics_top_assertions
bind spics_top spics_top_assertions i_chk (.clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_sel,
  .sfr_bit_val, .sfr_wdata, .sfr_rd, .sfr_rdata, .spi_irq_en, .spi_irq, .sck_out, .sck_oe, .mosi_oe,
  .slave_select_line_out, .slave_select_line_oe);
`default_nettype wire

// >>> bench/spi_control_status_logic_tb_top.sv
// self-checking bench of the spi control and status logic
`timescale 1ns/1ps
`default_nettype none
`include "spics_params.svh"
module spi_control_status_logic_tb_top;
  import spics_pkg::*;
  logic        clk, arst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, spi_irq_en, spi_irq;
  logic [7:0]  sfr_addr, part_tx, part_rx, d, v, t, mrx;
  logic [2:0]  sfr_bit_sel;
  spics_byte_t sfr_wdata, sfr_rdata;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
  logic        tb_sck, tb_mosi, tb_ss, part_miso, sck_w, mosi_w, miso_w, ss_w;
  logic [7:0]  exp_rx[$];
  int          miscompares, total_checks;
  // wire levels from the dut's enables, else the bench or the far-side part
  assign sck_w  = sck_oe ? sck_out : tb_sck;
  assign mosi_w = mosi_oe ? mosi_out : tb_mosi;
  assign miso_w = miso_oe ? miso_out : part_miso;
  assign ss_w   = ss_oe ? ss_out : tb_ss;
  spics_top i_dut (.clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_wdata,
    .sfr_rd, .sfr_rdata, .spi_irq_en, .spi_irq, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w),
    .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .slave_select_line_in(ss_w),
    .slave_select_line_out(ss_out), .slave_select_line_oe(ss_oe));
  spics_slave_model i_part (.sck(sck_w), .mosi(mosi_w), .sel_n(ss_w), .miso(part_miso), .tx_byte(part_tx),
    .rx_byte(part_rx));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] dat);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = dat;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic bit_wr(logic [2:0] b, logic val);
    @(negedge clk);
    sfr_addr    = `SPICS_CTL_ADDR;
    sfr_bit_sel = b;
    sfr_bit_val = val;
    sfr_bit_wr  = 1'b1;
    @(negedge clk);
    sfr_bit_wr = 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    v      = sfr_rdata;
  endtask
  task automatic wait_done;
    for (int n = 0; n < 100; n++) begin
      rd_reg(`SPICS_CTL_ADDR);
      if (v[7] === 1'b1) return;
    end
    miscompares++;
    $display("mismatch done_flag expected 1 seen 0");
    wrap_up();
  endtask
  // link clock phase unrelated to the system clock
  task automatic send_slave(logic [7:0] b);
    #7;
    for (int k = 7; k >= 0; k--) begin
      tb_mosi = b[k];
      // far-side master samples miso at its own rising edge
      #100 mrx = {mrx[6:0], miso_w};
      tb_sck = 1'b1;
      #100 tb_sck = 1'b0;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    {arst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, tb_sck, tb_mosi} = 7'h00;
    {sfr_addr, sfr_wdata, sfr_bit_sel, part_tx} = 27'h000_0000;
    {spi_irq_en, tb_ss} = 2'h3;
    void'($urandom(32'h4a8c_7778));
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    rd_reg(`SPICS_CTL_ADDR);
    chk("ctl_rst", 8'h06, v);
    rd_reg(8'h55);
    chk("unmapped", 8'h00, v);
    wr_reg(`SPICS_CFG_ADDR, 8'h40);
    for (int i = 0; i < 2; i++) begin
      d       = 8'($urandom);
      part_tx = 8'($urandom);
      wr_reg(`SPICS_CTL_ADDR, 8'h0D);
      chk("ss_hi", 8'h03, {6'h00, ss_oe, ss_out});
      wr_reg(`SPICS_CTL_ADDR, 8'h09);
      chk("ss_lo", 8'h02, {6'h00, ss_oe, ss_out});
      @(negedge clk);
      sfr_addr  = `SPICS_DAT_ADDR;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      // second pass writes again while the buffer is full
      @(negedge clk);
      sfr_wdata = ~d;
      sfr_wr    = (i == 1);
      @(negedge clk);
      sfr_wr = 1'b0;
      wait_done();
      chk("mosi_byte", d, part_rx);
      rd_reg(`SPICS_DAT_ADDR);
      chk("miso_byte", part_tx, v);
      rd_reg(`SPICS_CTL_ADDR);
      chk("ctl_done", (i == 1) ? 8'hCB : 8'h8B, v);
      chk("irq", 8'h01, 8'(spi_irq));
    end
    spi_irq_en = 1'b0;
    #1 chk("irq_mask", 8'h00, 8'(spi_irq));
    spi_irq_en = 1'b1;
    wr_reg(`SPICS_CTL_ADDR, 8'h01);
    chk("ss_3w", 8'h00, 8'(ss_oe));
    wr_reg(`SPICS_CTL_ADDR, 8'h05);
    tb_ss = 1'b0;
    rd_reg(`SPICS_CTL_ADDR);
    rd_reg(`SPICS_CTL_ADDR);
    chk("mode_fault", 8'h27, v);
    wr_reg(`SPICS_CFG_ADDR, 8'h00);
    wr_reg(`SPICS_CTL_ADDR, 8'h05);
    // slave answers the first byte with a preloaded one
    t = 8'($urandom);
    wr_reg(`SPICS_DAT_ADDR, t);
    // three bytes into a two-entry buffer, nothing read meanwhile
    for (int j = 0; j < 3; j++) begin
      d = 8'($urandom);
      if (exp_rx.size() < 2) exp_rx.push_back(d);
      send_slave(d);
      wait_done();
      chk("ctl_slave", (j == 0) ? 8'h87 : 8'h97, v);
      if (j == 0) chk("miso_slave", t, mrx);
      bit_wr(3'h7, 1'b0);
    end
    while (exp_rx.size() > 0) begin
      rd_reg(`SPICS_DAT_ADDR);
      chk("rx_slave", exp_rx.pop_front(), v);
    end
    rd_reg(`SPICS_CFG_ADDR);
    chk("rx_empty", 8'h01, 8'(v[0]));
    bit_wr(3'h4, 1'b0);
    bit_wr(3'h0, 1'b0);
    rd_reg(`SPICS_CTL_ADDR);
    chk("ctl_off", 8'h06, v);
    chk("irq_off", 8'h00, 8'(spi_irq));
    wrap_up();
  end
endmodule // spi_control_status_logic_tb_top
`default_nettype wire
